// [verilog/phy_mii_regs_defines.vh]
`ifndef PHY_MII_REGS_DEFINES_VH
`define PHY_MII_REGS_DEFINES_VH

// ****************************************************************
// Management register addresses
// ****************************************************************
`define REGAD_BASIC_CONTROL   5'h00
`define REGAD_BASIC_STATUS    5'h01
`define REGAD_ID_UPPER        5'h02
`define REGAD_ID_LOWER        5'h03
`define REGAD_ADVERTISEMENT   5'h04
`define REGAD_PARTNER_ABILITY 5'h05
`define REGAD_CABLE_DIAG      5'h1D
`define REGAD_SPECIAL_CTRL    5'h1F

// ****************************************************************
// Default management PHY address of the first port
// ****************************************************************
`define PHYAD_BASE_DEFAULT    5'h01

// ****************************************************************
// Identifier words (arbitrary values)
// ****************************************************************
`define PHY_ID_UPPER_VALUE    16'h0ABC
`define PHY_ID_LOWER_VALUE    16'hD5E0

// ****************************************************************
// Basic status fields
// ****************************************************************
`define BSR_ABILITY_MSB       14
`define BSR_ABILITY_LSB       11
`define BSR_ABILITY_VALUE     4'hF
`define BSR_NEG_DONE_BIT      5
`define BSR_FAR_FAULT_BIT     4
`define BSR_NEG_ABLE_BIT      3
`define BSR_LINK_BIT          2

// ****************************************************************
// Advertisement / partner ability fields
// ****************************************************************
`define ADV_PAUSE_BIT         10
`define ADV_RSVD_BIT          9
`define ADV_TECH_MSB          8
`define ADV_TECH_LSB          5
`define ADV_SELECTOR_MSB      4
`define ADV_SELECTOR_VALUE    5'h01
`define ADV_RESET_VALUE       5'h1F
`define ADV_RSVD_RESET        1'h0

// ****************************************************************
// 8-bit switch register fields
// ****************************************************************
`define CTRL_ADV_MSB          4
`define STAT_PARTNER_MSB      4
`define STAT_LINK_BIT         5
`define STAT_NEG_DONE_BIT     6

`endif

// [verilog/phy_port_view.v]
`timescale 1ns/1ns
`include "phy_mii_regs_defines.vh"

module phy_port_view (
	input  wire        ref_clk_i,
	input  wire        nrst_i,
	input  wire [4:0]  reg_addr_i,
	input  wire        adv_wr_i,
	input  wire [15:0] mgmt_wdata_i,
	input  wire        ctrl_wr_i,
	input  wire [7:0]  ctrl_wdata_i,
	input  wire        neg_enable_i,
	input  wire [7:0]  port_status_i,
	input  wire        far_fault_i,
	output wire [4:0]  ctrl_adv_o,
	output reg  [15:0] rdata_o
);

	reg  [4:0]  adv_q;
	reg  [4:0]  adv_d;
	reg         rsvd_q;
	reg         rsvd_d;
	wire [15:0] status_word;
	wire [15:0] adv_word;
	wire [15:0] partner_word;

	// ****************************************************************
	// Shared advertisement storage
	// ****************************************************************
	// Single copy serves both views, so the alias can never drift.
	always @* begin
		adv_d  = adv_q;
		rsvd_d = rsvd_q;
		if (adv_wr_i) begin
			adv_d  = {mgmt_wdata_i[`ADV_PAUSE_BIT],
			          mgmt_wdata_i[`ADV_TECH_MSB:`ADV_TECH_LSB]};
			rsvd_d = mgmt_wdata_i[`ADV_RSVD_BIT];
		end else if (ctrl_wr_i) begin
			adv_d  = ctrl_wdata_i[`CTRL_ADV_MSB:0];
		end
	end

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			adv_q  <= `ADV_RESET_VALUE;
			rsvd_q <= `ADV_RSVD_RESET;
		end else begin
			adv_q  <= adv_d;
			rsvd_q <= rsvd_d;
		end
	end

	assign ctrl_adv_o = adv_q;

	// ****************************************************************
	// Register images
	// ****************************************************************
	assign status_word = {1'h0,
	                      `BSR_ABILITY_VALUE,
	                      4'h0,
	                      1'h0,
	                      port_status_i[`STAT_NEG_DONE_BIT],
	                      far_fault_i,
	                      neg_enable_i,
	                      port_status_i[`STAT_LINK_BIT],
	                      1'h0,
	                      1'h0};

	assign adv_word = {5'h00, adv_q[4], rsvd_q, adv_q[3:0], `ADV_SELECTOR_VALUE};

	assign partner_word = {5'h00,
	                       port_status_i[`STAT_PARTNER_MSB],
	                       1'b0,
	                       port_status_i[3:0],
	                       5'h00};

	// Unsupported addresses read zero
	always @* begin
		if (reg_addr_i == `REGAD_BASIC_STATUS) begin
			rdata_o = status_word;
		end else if (reg_addr_i == `REGAD_ID_UPPER) begin
			rdata_o = `PHY_ID_UPPER_VALUE;
		end else if (reg_addr_i == `REGAD_ID_LOWER) begin
			rdata_o = `PHY_ID_LOWER_VALUE;
		end else if (reg_addr_i == `REGAD_ADVERTISEMENT) begin
			rdata_o = adv_word;
		end else if (reg_addr_i == `REGAD_PARTNER_ABILITY) begin
			rdata_o = partner_word;
		end else begin
			rdata_o = 16'h0000;
		end
	end

endmodule

// [verilog/phy_mii_status_autoneg_regs.v]
// Functional notes
// - Status bit 15 always reads zero
// - Status bits 14..11 always read one
// - Status bit 5 mirrors negotiation done
// - Status bit 4 mirrors far-end fault
// - Status bit 3 follows negotiation enable
// - Status bit 0 always reads zero
// - Upper identifier word is read-only
// - Lower identifier word is read-only
// - Advert bit 10 pause, aliases control bit 4
// - Advert bit 8 aliases control bit 3
// - Advert bit 7 aliases control bit 2
// - Advert bit 6 aliases control bit 1
// - Advert bit 5 aliases control bit 0
// - Partner bit 10 mirrors status bit 4
// - Partner bit 8 mirrors status bit 3
// - Partner bit 7 mirrors status bit 2
// - Partner bit 6 mirrors status bit 1
// - Partner bit 5 mirrors status bit 0
// - PHY addresses default 1 and 2, programmable
// - Only listed register addresses are implemented
//
`timescale 1ns/1ns
`include "phy_mii_regs_defines.vh"

module phy_mii_status_autoneg_regs #(
	parameter NUM_PORTS = 2
) (
	input  wire                   ref_clk_i,
	input  wire                   nrst_i,
	input  wire [4:0]             phy_base_i,
	input  wire [4:0]             mgmt_phy_addr_i,
	input  wire [4:0]             mgmt_reg_addr_i,
	input  wire                   mgmt_rd_i,
	input  wire                   mgmt_wr_i,
	input  wire [15:0]            mgmt_wdata_i,
	output reg  [15:0]            mgmt_rdata_o,
	output reg                    mgmt_rvalid_o,
	output reg                    mgmt_hit_o,
	input  wire [NUM_PORTS-1:0]   ctrl_wr_i,
	input  wire [7:0]             ctrl_wdata_i,
	input  wire [NUM_PORTS-1:0]   neg_enable_i,
	input  wire [8*NUM_PORTS-1:0] port_status_i,
	input  wire [NUM_PORTS-1:0]   far_fault_i,
	output wire [5*NUM_PORTS-1:0] ctrl_adv_o
);

	wire [NUM_PORTS-1:0]    port_sel;
	wire [16*NUM_PORTS-1:0] port_rdata;
	wire                    any_sel;
	reg  [15:0]             sel_rdata;
	reg  [15:0]             rdata_d;
	wire                    adv_addr;
	integer                 k;

	assign adv_addr = (mgmt_reg_addr_i == `REGAD_ADVERTISEMENT);

	// ****************************************************************
	// Per-port register views
	// ****************************************************************
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
			localparam [31:0] PORT_IDX = p;
			wire       [4:0]  port_addr;
			// Consecutive addresses from the programmable base, wrapping at 31
			assign port_addr   = phy_base_i + PORT_IDX[4:0];
			assign port_sel[p] = (mgmt_phy_addr_i == port_addr);

			phy_port_view u_view (
				.ref_clk_i     (ref_clk_i),
				.nrst_i        (nrst_i),
				.reg_addr_i    (mgmt_reg_addr_i),
				.adv_wr_i      (mgmt_wr_i & port_sel[p] & adv_addr),
				.mgmt_wdata_i  (mgmt_wdata_i),
				.ctrl_wr_i     (ctrl_wr_i[p]),
				.ctrl_wdata_i  (ctrl_wdata_i),
				.neg_enable_i  (neg_enable_i[p]),
				.port_status_i (port_status_i[8*p+7:8*p]),
				.far_fault_i   (far_fault_i[p]),
				.ctrl_adv_o    (ctrl_adv_o[5*p+4:5*p]),
				.rdata_o       (port_rdata[16*p+15:16*p])
			);
		end
	endgenerate

	assign any_sel = |port_sel;

	// ****************************************************************
	// Read path
	// ****************************************************************
	// Lowest port wins if more than 32 ports make addresses repeat.
	always @* begin
		sel_rdata = 16'h0000;
		for (k = NUM_PORTS - 1; k >= 0; k = k - 1) begin
			if (port_sel[k]) begin
				sel_rdata = port_rdata[16*k +: 16];
			end
		end
	end

	always @* begin
		rdata_d = mgmt_rdata_o;
		if (mgmt_rd_i) begin
			rdata_d = sel_rdata;
		end
	end

	always @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mgmt_rdata_o  <= 16'h0000;
			mgmt_rvalid_o <= 1'h0;
			mgmt_hit_o    <= 1'h0;
		end else begin
			mgmt_rdata_o  <= rdata_d;
			mgmt_rvalid_o <= mgmt_rd_i;
			mgmt_hit_o    <= (mgmt_rd_i | mgmt_wr_i) & any_sel;
		end
	end

endmodule

// [test/mgmt_station.sv]
`timescale 1ns/1ns
module mgmt_station (
	input  wire        ref_clk_i,
	input  wire [15:0] rdata_i,
	input  wire        rvalid_i,
	output reg  [4:0]  phy_addr_o,
	output reg  [4:0]  reg_addr_o,
	output reg         rd_o,
	output reg         wr_o,
	output reg  [15:0] wdata_o
);
	initial begin
		{phy_addr_o, reg_addr_o, rd_o, wr_o, wdata_o} = 0;
	end
	// ************
	// One transfer
	// ************
	// Called at a rising edge; the request is taken one edge later
	task xfer(input logic w, input logic [4:0] pa, ra, input logic [15:0] d,
		output logic [15:0] q);
		begin
			phy_addr_o <= pa;
			reg_addr_o <= ra;
			wdata_o <= d;
			rd_o <= !w;
			wr_o <= w;
			@(posedge ref_clk_i);
			rd_o <= 1'b0;
			wr_o <= 1'b0;
			// Idle bus shows no stale data or register address; the PHY address stays
			wdata_o <= ~d;
			reg_addr_o <= ~ra;
			@(negedge ref_clk_i);
			q = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
			@(posedge ref_clk_i);
		end
	endtask
endmodule

// [test/phy_regs_properties.sv]
`timescale 1ns/1ns
`include "phy_mii_regs_defines.vh"
module phy_regs_checker #(parameter NUM_PORTS = 2) (
	input wire                   ref_clk_i,
	input wire                   nrst_i,
	input wire [4:0]             phy_base_i,
	input wire [4:0]             mgmt_phy_addr_i,
	input wire [4:0]             mgmt_reg_addr_i,
	input wire                   mgmt_rd_i,
	input wire                   mgmt_wr_i,
	input wire [15:0]            mgmt_wdata_i,
	input wire [15:0]            mgmt_rdata_o,
	input wire                   mgmt_rvalid_o,
	input wire                   mgmt_hit_o,
	input wire [NUM_PORTS-1:0]   ctrl_wr_i,
	input wire [NUM_PORTS-1:0]   neg_enable_i,
	input wire [8*NUM_PORTS-1:0] port_status_i,
	input wire [NUM_PORTS-1:0]   far_fault_i,
	input wire [5*NUM_PORTS-1:0] ctrl_adv_o
);
	wire p1 = mgmt_phy_addr_i == phy_base_i;
	// Distance from the base, modulo 32: ports sit at offsets below NUM_PORTS
	wire [4:0] addr_off = mgmt_phy_addr_i - phy_base_i;
	wire s1 = mgmt_rd_i && p1 && mgmt_reg_addr_i == 5'h01;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rvalid; mgmt_rd_i |=> mgmt_rvalid_o; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_fixed; s1 |=> mgmt_rdata_o[15:11] == 5'h0F && !mgmt_rdata_o[0]; endproperty
	a_fixed: assert property (p_fixed) else $error("fixed status bits");
	property p_done; s1 |=> mgmt_rdata_o[5] == $past(port_status_i[6]); endproperty
	a_done: assert property (p_done) else $error("done bit");
	property p_fault; s1 |=> mgmt_rdata_o[4] == $past(far_fault_i[0]); endproperty
	a_fault: assert property (p_fault) else $error("fault bit");
	property p_able; s1 |=> mgmt_rdata_o[3] == $past(neg_enable_i[0]); endproperty
	a_able: assert property (p_able) else $error("able bit");
	property p_id; mgmt_rd_i && p1 && mgmt_reg_addr_i == 5'h02
		|=> mgmt_rdata_o == `PHY_ID_UPPER_VALUE; endproperty
	a_id: assert property (p_id) else $error("upper id");
	property p_lp; mgmt_rd_i && p1 && mgmt_reg_addr_i == 5'h05 |=> mgmt_rdata_o ==
		{5'h00, $past(port_status_i[4]), 1'b0, $past(port_status_i[3:0]), 5'h00}; endproperty
	a_lp: assert property (p_lp) else $error("partner word");
	property p_adv; mgmt_wr_i && p1 && mgmt_reg_addr_i == 5'h04 |=>
		ctrl_adv_o[4:0] == {$past(mgmt_wdata_i[10]), $past(mgmt_wdata_i[8:5])}; endproperty
	a_adv: assert property (p_adv) else $error("advert alias");
	property p_uns; mgmt_rd_i && mgmt_reg_addr_i > 5'h05 |=> mgmt_rdata_o == 16'h0000; endproperty
	a_uns: assert property (p_uns) else $error("unsupported read");
	property p_ro; !mgmt_wr_i && !ctrl_wr_i |=> $stable(ctrl_adv_o); endproperty
	a_ro: assert property (p_ro) else $error("alias moved");
	property p_hit; mgmt_rd_i || mgmt_wr_i |=>
		mgmt_hit_o == $past(addr_off < NUM_PORTS); endproperty
	a_hit: assert property (p_hit) else $error("address hit");
endmodule
bind phy_mii_status_autoneg_regs phy_regs_checker #(.NUM_PORTS(NUM_PORTS)) i_phy_regs_checker (.*);

// [test/tb_top.sv]
`timescale 1ns/1ns
`include "phy_mii_regs_defines.vh"
module tb_top;
	reg     ref_clk_i, nrst_i;
	reg     [4:0] phy_base;
	reg     [1:0] ctrl_wr, neg_enable, far_fault;
	reg     [7:0] ctrl_wdata;
	reg     [15:0] port_status, q;
	wire    [4:0] pa, ra;
	wire    rd, wr, rvalid;
	wire    [15:0] wdata, rdata;
	wire    [9:0] ctrl_adv;
	integer err_count = 0, num_checks = 0, cyc = 0;
	phy_mii_status_autoneg_regs i_phy_mii_status_autoneg_regs (.ref_clk_i(ref_clk_i),
		.nrst_i(nrst_i), .phy_base_i(phy_base), .mgmt_phy_addr_i(pa), .mgmt_reg_addr_i(ra),
		.mgmt_rd_i(rd), .mgmt_wr_i(wr), .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata),
		.mgmt_rvalid_o(rvalid), .mgmt_hit_o(), .ctrl_wr_i(ctrl_wr), .ctrl_wdata_i(ctrl_wdata),
		.neg_enable_i(neg_enable), .port_status_i(port_status), .far_fault_i(far_fault),
		.ctrl_adv_o(ctrl_adv));
	mgmt_station i_mgmt_station (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.phy_addr_o(pa), .reg_addr_o(ra), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
	// **************
	// Checks and end
	// **************
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %0s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task rdc(input logic [4:0] p, r, input logic [15:0] e);
		i_mgmt_station.xfer(1'b0, p, r, 16'h0000, q);
		chk("rdata", q, e);
	endtask
	task wrc(input logic [4:0] p, r, input logic [15:0] d);
		i_mgmt_station.xfer(1'b1, p, r, d, q);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		ref_clk_i = 0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	// Whole sequence needs well under 200 cycles
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			complete_run;
		end
	end
	initial begin
		{nrst_i, ctrl_wr, ctrl_wdata} = 0;
		phy_base = 5'h01;
		neg_enable = 2'b01;
		far_fault = 2'b01;
		port_status = 16'h005A;
		repeat (5) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		@(posedge ref_clk_i);
		chk("ctrl_adv", {6'h00, ctrl_adv}, 16'h03FF);
		rdc(1, 4, 16'h05E1);
		rdc(1, 1, 16'h7838);
		rdc(2, 1, 16'h7800);
		rdc(1, 5, 16'h0540);
		rdc(2, 5, 16'h0000);
		wrc(2, 2, 16'h0000);
		rdc(2, 2, `PHY_ID_UPPER_VALUE);
		rdc(1, 3, `PHY_ID_LOWER_VALUE);
		rdc(1, 2, `PHY_ID_UPPER_VALUE);
		wrc(2, 4, 16'hFFFF);
		rdc(2, 4, 16'h07E1);
		wrc(2, 4, 16'h0000);
		rdc(2, 4, 16'h0001);
		chk("ctrl_adv", {6'h00, ctrl_adv}, 16'h001F);
		wrc(1, 4, 16'hF53F);
		rdc(1, 4, 16'h0521);
		chk("ctrl_adv", {6'h00, ctrl_adv}, 16'h0019);
		ctrl_wdata <= 8'hEA;
		ctrl_wr <= 2'b01;
		@(posedge ref_clk_i);
		ctrl_wr <= 2'b00;
		@(posedge ref_clk_i);
		rdc(1, 4, 16'h0141);
		port_status <= 16'h3F00;
		neg_enable <= 2'b10;
		far_fault <= 2'b10;
		@(posedge ref_clk_i);
		rdc(2, 1, 16'h781C);
		rdc(2, 5, 16'h05E0);
		rdc(1, 6, 16'h0000);
		rdc(1, 5'h1E, 16'h0000);
		rdc(2, 5'h1D, 16'h0000);
		rdc(3, 1, 16'h0000);
		phy_base <= 5'h08;
		@(posedge ref_clk_i);
		rdc(5'h08, 4, 16'h0141);
		rdc(5'h09, 4, 16'h0001);
		rdc(1, 4, 16'h0000);
		complete_run;
	end
endmodule
